// file: hdl/usb_ep_pkg.sv
// package for the endpoint bank handler: types and constants
// assumes a single clock domain (mclk, 100 MHz)
package usb_ep_pkg;
  localparam int DATA_W     = 8;
  localparam int MAX_PKT    = 64;
  localparam int CNT_W      = 11;
  localparam int DEPTH_W    = 6;
  // suspend after 3 ms of idle bus, counted in mclk cycles
  localparam int CLK_MHZ    = 100;
  localparam int IDLE_US    = 3000;
  localparam int IDLE_CYC   = IDLE_US * CLK_MHZ;
  localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;

  // handshake answers to the bus engine
  typedef enum logic [1:0] {
    HS_NONE  = 2'b00,
    HS_ACK   = 2'b01,
    HS_NAK   = 2'b10,
    HS_STALL = 2'b11
  } handshake_t;

  // device states
  typedef enum logic [1:0] {
    DEV_DEFAULT    = 2'b00,
    DEV_ADDRESS    = 2'b01,
    DEV_CONFIGURED = 2'b10
  } dev_state_t;

  // token events from the serial engine
  typedef struct packed {
    logic inTok;     // in token for this endpoint
    logic outTok;    // out data packet start
    logic outByteV;  // one out byte valid
    logic [DATA_W-1:0] outByte;
    logic outEnd;    // out packet ended, crc good
    logic hostAck;   // host acked our in data
    logic setupTok;  // setup packet seen
  } bus_evt_t;

  // endpoint status for firmware
  typedef struct packed {
    logic txPacketReady;
    logic txComplete;
    logic rxBank0Full;
    logic rxBank1Full;
    logic stallSentFlag;
    logic [CNT_W-1:0] rxByteCount;
  } ep_status_t;
endpackage

// file: hdl/usb_ep_bank.sv
// one packet bank of flip-flop storage with byte counter
// assumes writer and reader never use one bank at once
module usb_ep_bank
  import usb_ep_pkg::*;
#(
  parameter int DEPTH = MAX_PKT
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  // fill side
  input  wire logic              clr,
  input  wire logic              wrEn,
  input  wire logic [DATA_W-1:0] wrData,
  // drain side
  input  wire logic              rdRewind,
  input  wire logic              rdEn,
  output logic      [DATA_W-1:0] rdData,
  output logic      [CNT_W-1:0]  count
);
  logic [DATA_W-1:0] mem [DEPTH];
  logic [CNT_W-1:0]  rdPtr_r;

  // byte count, saturates at depth
  always_ff @(posedge mclk) begin
    if (reset || clr) begin
      count <= CNT_ZERO;
    end else if (wrEn && count < CNT_W'(DEPTH)) begin
      count <= count + 1'b1;
    end
  end

  // storage write
  always_ff @(posedge mclk) begin
    if (wrEn && count < CNT_W'(DEPTH)) begin
      mem[count[DEPTH_W-1:0]] <= wrData;
    end
  end

  // sequential read pointer
  always_ff @(posedge mclk) begin
    if (reset || rdRewind) begin
      rdPtr_r <= CNT_ZERO;
    end else if (rdEn) begin
      rdPtr_r <= rdPtr_r + 1'b1;
    end
  end

  assign rdData = mem[rdPtr_r[DEPTH_W-1:0]];
endmodule

// file: hdl/usb_endpoint_bank_handler.sv
// endpoint bank handler: single or ping-pong banks, in/out/stall handshakes
// assumes the serial engine delivers decoded events on mclk
module usb_endpoint_bank_handler
  import usb_ep_pkg::*;
#(
  parameter int DEPTH     = MAX_PKT,
  parameter int IDLE_CNT  = IDLE_CYC
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  // configuration
  input  wire logic              dualBank,
  input  wire logic              isDefaultEp,
  // bus engine events and answer
  input  wire bus_evt_t          busEvt,
  input  wire logic              busActive,
  input  wire logic              busReset,
  input  wire logic              inByteTake,
  output handshake_t             handshake,
  output logic      [DATA_W-1:0] inByte,
  output logic                   inBank,
  // firmware control strobes
  input  wire logic              setTxReady,
  input  wire logic              clrTxComplete,
  input  wire logic              clrRxBank0,
  input  wire logic              clrRxBank1,
  input  wire logic              forceStallReq,
  input  wire logic              clrStallSent,
  input  wire logic              setAddressDone,
  input  wire logic              setConfigDone,
  input  wire logic              remoteWakeEn,
  input  wire logic              remoteWakeReq,
  // firmware fifo data port
  input  wire logic              fifoWr,
  input  wire logic [DATA_W-1:0] fifoWrData,
  input  wire logic              fifoRd,
  output logic      [DATA_W-1:0] fifoRdData,
  // status out
  output ep_status_t             status,
  output logic                   epIrq,
  output dev_state_t             devState,
  output logic                   suspended,
  output logic                   wakeResume
);
  // synchronised pin-level bus activity
  logic actMeta_r, actSync_r;
  always_ff @(posedge mclk) begin
    actMeta_r <= busActive;
    actSync_r <= actMeta_r;
  end

  // ---- bank bookkeeping ----
  logic       txArmed_r   [2];  // bank armed for in
  logic       txFwBank_r;       // bank firmware fills next
  logic       txBusBank_r;      // bank bus sends next
  logic       rxFull_r    [2];
  logic       rxWrBank_r;       // bank next out lands in
  logic       rxRdBank_r;       // bank firmware reads
  logic       outActive_r;
  logic       txComplete_r, stall_sent_flag_r, stallPend_r;
  logic [CNT_W-1:0] bankCnt [2];
  logic [DATA_W-1:0] bankRd [2];

  function automatic logic useBank(input logic sel);
    return dualBank ? sel : 1'b0;
  endfunction
  // ownership: out packet accepted only into a free bank
  logic outTarget, outFree;
  assign outTarget = useBank(rxWrBank_r);
  assign outFree   = !rxFull_r[outTarget] && !txArmed_r[outTarget];
  // per-bank strobes
  logic bankClr [2], bankWr [2], bankRew [2], bankRd_en [2];
  logic [DATA_W-1:0] bankWrData [2];
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      bankClr[b]    = busReset || (b == 0 ? clrRxBank0 : clrRxBank1);
      bankWr[b]     = 1'b0;
      bankRew[b]    = 1'b0;
      bankRd_en[b]  = 1'b0;
      bankWrData[b] = fifoWrData;
    end
    // out packet start clears target bank
    if (busEvt.outTok && outFree && !forceStallReq) begin
      bankClr[outTarget] = 1'b1;
      bankRew[outTarget] = 1'b1;
    end
    if (busEvt.outByteV && outActive_r) begin
      bankWr[outTarget]     = 1'b1;
      bankWrData[outTarget] = busEvt.outByte;
    end
    // firmware write fills its in bank
    if (fifoWr) begin
      bankWr[useBank(txFwBank_r)] = 1'b1;
    end
    if (fifoRd) begin
      bankRd_en[useBank(rxRdBank_r)] = 1'b1;
    end
    // in token starts sending from the bus bank
    if (busEvt.inTok && txArmed_r[useBank(txBusBank_r)] && !forceStallReq) begin
      bankRew[useBank(txBusBank_r)] = 1'b1;
    end
    if (inByteTake) begin
      bankRd_en[useBank(txBusBank_r)] = 1'b1;
    end
    if (busEvt.hostAck && txArmed_r[useBank(txBusBank_r)]) begin // released: empty it
      bankClr[useBank(txBusBank_r)] = 1'b1;
    end
    // armed bank reads from its first byte
    if (setTxReady) begin
      bankRew[useBank(txFwBank_r)] = 1'b1;
    end
  end

  // bank instances
  for (genvar g = 0; g < 2; g++) begin : gBank
    usb_ep_bank #(.DEPTH(DEPTH)) uBank (
      .mclk     (mclk),
      .reset    (reset),
      .clr      (bankClr[g]),
      .wrEn     (bankWr[g]),
      .wrData   (bankWrData[g]),
      .rdRewind (bankRew[g]),
      .rdEn     (bankRd_en[g]),
      .rdData   (bankRd[g]),
      .count    (bankCnt[g])
    );
  end

  // in side: arm, send, release
  always_ff @(posedge mclk) begin
    if (reset || busReset) begin
      txArmed_r[0] <= 1'b0;
      txArmed_r[1] <= 1'b0;
      txFwBank_r   <= 1'b0;
      txBusBank_r  <= 1'b0;
    end else begin
      if (setTxReady) begin
        txArmed_r[useBank(txFwBank_r)] <= 1'b1;
        txFwBank_r <= dualBank ? !txFwBank_r : 1'b0;
      end
      if (busEvt.hostAck && txArmed_r[useBank(txBusBank_r)]) begin
        txArmed_r[useBank(txBusBank_r)] <= 1'b0;
        txBusBank_r <= dualBank ? !txBusBank_r : 1'b0;
      end
    end
  end

  // tx complete sticky, set beats clear
  always_ff @(posedge mclk) begin
    if (reset || busReset) begin
      txComplete_r <= 1'b0;
    end else if (busEvt.hostAck && txArmed_r[useBank(txBusBank_r)]) begin
      txComplete_r <= 1'b1;
    end else if (clrTxComplete) begin
      txComplete_r <= 1'b0;
    end
  end

  // out side: receive and bank alternation
  always_ff @(posedge mclk) begin
    if (reset || busReset) begin
      outActive_r <= 1'b0;
      rxFull_r[0] <= 1'b0;
      rxFull_r[1] <= 1'b0;
      rxWrBank_r  <= 1'b0;
      rxRdBank_r  <= 1'b0;
    end else begin
      if (busEvt.outTok) begin
        outActive_r <= outFree && !forceStallReq;
      end
      if (clrRxBank0) begin
        rxFull_r[0] <= 1'b0;
      end
      if (clrRxBank1) begin
        rxFull_r[1] <= 1'b0;
      end
      if (clrRxBank0 || clrRxBank1) begin
        rxRdBank_r <= dualBank ? !clrRxBank1 : 1'b0;
      end
      if (busEvt.outEnd && outActive_r) begin
        outActive_r          <= 1'b0;
        rxFull_r[outTarget]  <= 1'b1;
        rxWrBank_r           <= dualBank ? !rxWrBank_r : 1'b0;
      end
    end
  end

  // stall: answer stall then flag it
  always_ff @(posedge mclk) begin
    if (reset || busReset) begin
      stall_sent_flag_r <= 1'b0;
    end else if (stallPend_r) begin
      stall_sent_flag_r <= 1'b1;
    end else if (clrStallSent) begin
      stall_sent_flag_r <= 1'b0;
    end
  end

  // handshake selection
  always_ff @(posedge mclk) begin
    if (reset) begin
      handshake   <= HS_NONE;
      stallPend_r <= 1'b0;
    end else begin
      stallPend_r <= 1'b0;
      handshake   <= HS_NONE;
      if ((busEvt.inTok || busEvt.outEnd) && forceStallReq) begin
        handshake   <= HS_STALL;
        stallPend_r <= 1'b1;
      end else if (busEvt.inTok && !txArmed_r[useBank(txBusBank_r)]) begin
        handshake   <= HS_NAK;
      end else if (busEvt.outEnd) begin
        handshake   <= outActive_r ? HS_ACK : HS_NAK;
      end
    end
  end

  // data and status registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      inByte     <= '0;
      inBank     <= 1'b0;
      fifoRdData <= '0;
      status     <= '0;
      epIrq      <= 1'b0;
    end else begin
      inByte     <= bankRd[useBank(txBusBank_r)];
      inBank     <= txBusBank_r;
      fifoRdData <= bankRd[useBank(rxRdBank_r)];
      status.txPacketReady <= txArmed_r[0] || txArmed_r[1];
      status.txComplete    <= txComplete_r;
      status.rxBank0Full   <= rxFull_r[0];
      status.rxBank1Full   <= rxFull_r[1];
      status.stallSentFlag <= stall_sent_flag_r;
      status.rxByteCount   <= bankCnt[useBank(rxRdBank_r)];
      epIrq <= txComplete_r || rxFull_r[0] || rxFull_r[1] || stall_sent_flag_r;
    end
  end

  // device state from bus reset and default endpoint requests
  always_ff @(posedge mclk) begin
    if (reset || busReset) begin
      devState <= DEV_DEFAULT;
    end else if (isDefaultEp && setConfigDone && devState == DEV_ADDRESS) begin
      devState <= DEV_CONFIGURED;
    end else if (isDefaultEp && setAddressDone && devState == DEV_DEFAULT) begin
      devState <= DEV_ADDRESS;
    end
  end

  // idle counter for suspend, activity resumes
  logic [31:0] idleCnt_r;
  always_ff @(posedge mclk) begin
    if (reset || actSync_r) begin
      idleCnt_r <= '0;
      suspended <= 1'b0;
    end else if (idleCnt_r >= 32'(IDLE_CNT - 1)) begin
      suspended <= 1'b1;
    end else begin
      idleCnt_r <= idleCnt_r + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wakeResume <= 1'b0;
    end else begin
      wakeResume <= suspended && remoteWakeEn && remoteWakeReq;
    end
  end
endmodule

// file: tb/usb_ep_checker.sv
// checker: handshake, flag and suspend timing at the handler ports
// assumes a bind onto the handler; one clock, synchronous reset
module usb_ep_checker
  import usb_ep_pkg::*;
#(
  parameter int IDLE_CNT = IDLE_CYC
) (
  // clock, reset, config
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       dualBank,
  // bus side
  input wire bus_evt_t   busEvt,
  input wire logic       busActive,
  input wire handshake_t handshake,
  // firmware side
  input wire logic       setTxReady,
  input wire logic       forceStallReq,
  input wire ep_status_t status,
  input wire logic       epIrq,
  input wire logic       suspended
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // idle bus cycles, saturating
  int idleCnt;
  always_ff @(posedge mclk) begin
    if (reset || busActive) idleCnt <= 0;
    else if (idleCnt < IDLE_CNT + 8) idleCnt <= idleCnt + 1;
  end
  stall_answer_a: assert property (
    busEvt.inTok && forceStallReq |=> handshake == HS_STALL) else $error("no stall");
  stall_flag_a: assert property (
    handshake == HS_STALL |-> ##[1:3] status.stallSentFlag) else $error("no stall flag");
  irq_pend_a: assert property (
    (status.txComplete || status.rxBank0Full || status.rxBank1Full || status.stallSentFlag)
    [*2] |-> epIrq) else $error("irq not pending");
  in_nak_a: assert property (
    busEvt.inTok && !status.txPacketReady && !forceStallReq && !setTxReady
    && !$past(setTxReady) |=> handshake == HS_NAK) else $error("in not nakked");
  txc_ack_a: assert property (
    $rose(status.txComplete) |-> $past(busEvt.hostAck, 2) || $past(busEvt.hostAck, 3))
    else $error("tx complete without ack");
  out_nak_a: assert property (
    busEvt.outEnd && !forceStallReq && status.rxBank0Full && (status.rxBank1Full || !dualBank)
    |=> handshake == HS_NAK) else $error("out not nakked");
  rx_full_a: assert property (
    handshake == HS_ACK && $past(busEvt.outEnd)
    |-> ##[1:2] (status.rxBank0Full || status.rxBank1Full)) else $error("no rx flag");
  suspend_a: assert property (
    idleCnt == IDLE_CNT + 8 |-> suspended) else $error("no suspend");
  resume_a: assert property (
    busActive [*6] |-> !suspended) else $error("no resume");
endmodule

bind usb_endpoint_bank_handler usb_ep_checker #(.IDLE_CNT(IDLE_CNT)) u_usb_ep_checker (
  .mclk(mclk), .reset(reset), .dualBank(dualBank), .busEvt(busEvt), .busActive(busActive),
  .handshake(handshake), .setTxReady(setTxReady), .forceStallReq(forceStallReq),
  .status(status), .epIrq(epIrq), .suspended(suspended));

// file: tb/usb_host_model.sv
// host controller model: token and data events, handshake capture
// assumes one calling process; released data lines show inverted bytes
module usb_host_model
  import usb_ep_pkg::*;
(
  // clock and device answers
  input  wire logic        mclk,
  input  wire handshake_t  handshake,
  input  wire logic [7:0]  inByte,
  // events toward the device
  output bus_evt_t         busEvt,
  output logic             inByteTake
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    busEvt     = '0;
    inByteTake = 1'b0;
  end
  // out transaction: token, n bytes from b0 upward, end, answer
  task automatic outPkt(input int n, input logic [7:0] b0, output handshake_t hs);
    bus_evt_t e;
    e        = '0;
    e.outTok = 1'b1;
    @(posedge mclk) busEvt <= e;
    for (int i = 0; i < n; i++) begin
      e          = '0;
      e.outByteV = 1'b1;
      e.outByte  = b0 + 8'(i);
      @(posedge mclk) busEvt <= e;
    end
    e         = '0;
    e.outEnd  = 1'b1;
    e.outByte = ~busEvt.outByte;
    @(posedge mclk) busEvt <= e;
    e.outEnd = 1'b0;
    @(posedge mclk) busEvt <= e;
    @(posedge mclk) hs = handshake;
  endtask
  // in transaction: token, answer, first byte, optional ack
  task automatic inTrans(input bit ack, output handshake_t hs, output logic [7:0] b);
    bus_evt_t e;
    e       = '0;
    e.inTok = 1'b1;
    @(posedge mclk) busEvt <= e;
    @(posedge mclk) busEvt <= '0;
    @(posedge mclk) hs = handshake;
    repeat (2) @(posedge mclk);
    b = inByte;
    if (ack && hs != HS_NAK && hs != HS_STALL) begin
      @(posedge mclk) inByteTake <= 1'b1;
      e.inTok   = 1'b0;
      e.hostAck = 1'b1;
      @(posedge mclk) inByteTake <= 1'b0;
      @(posedge mclk) busEvt <= e;
      @(posedge mclk) busEvt <= '0;
    end
  endtask
endmodule

// file: tb/usb_endpoint_bank_handler_tb.sv
// self-checking bench for the endpoint bank handler
// assumes the host model beside it and the checker bound in
module usb_endpoint_bank_handler_tb import usb_ep_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] len; logic [10:0] cnt;} row_t;
  row_t rows [4] = '{'{8'h00, 11'h000}, '{8'h01, 11'h001}, '{8'h08, 11'h008}, '{8'h40, 11'h040}};
  logic       mclk, reset, dualBank, busActive, busReset, stallReq, fifoWr, fifoRd;
  logic [6:0] fw;  // tx ready, clr txc, clr rx0, clr rx1, clr stall, addressed, configured
  logic       defEp, wakeEn, wakeReq, wakeRes, inBk;
  logic [7:0] wrData, rdData, inByte, b;
  bus_evt_t   busEvt;
  handshake_t handshake, hs;
  ep_status_t status;
  dev_state_t devState;
  logic       inByteTake, epIrq, suspended;
  int         errCount, nChecks, cyc;
  usb_endpoint_bank_handler #(.IDLE_CNT(20)) u_usb_endpoint_bank_handler (
    .mclk(mclk), .reset(reset), .dualBank(dualBank), .isDefaultEp(defEp), .busEvt(busEvt),
    .busActive(busActive), .busReset(busReset), .inByteTake(inByteTake), .inBank(inBk),
    .handshake(handshake), .inByte(inByte), .setTxReady(fw[0]), .clrTxComplete(fw[1]),
    .clrRxBank0(fw[2]), .clrRxBank1(fw[3]), .forceStallReq(stallReq), .clrStallSent(fw[4]),
    .setAddressDone(fw[5]), .setConfigDone(fw[6]), .remoteWakeEn(wakeEn),
    .remoteWakeReq(wakeReq),
    .fifoWr(fifoWr), .fifoWrData(wrData), .fifoRd(fifoRd), .fifoRdData(rdData),
    .status(status), .epIrq(epIrq), .devState(devState), .suspended(suspended),
    .wakeResume(wakeRes));
  usb_host_model u_usb_host_model (.mclk(mclk), .handshake(handshake), .inByte(inByte),
    .busEvt(busEvt), .inByteTake(inByteTake));
  // clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      errCount++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // firmware strobe k, then let status settle
  task automatic fws(input int k);
    @(posedge mclk) fw <= 7'h01 << k;
    @(posedge mclk) fw <= 7'h00;
    repeat (3) @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge mclk);
    fifoWr <= 1'b1;
    wrData <= d;
    @(posedge mclk) fifoWr <= 1'b0;
  endtask
  task automatic rdChk(input int n, input logic [7:0] b0);
    for (int i = 0; i < n; i++) begin
      chk("fifo data", 16'(rdData), 16'(b0 + 8'(i)));
      @(posedge mclk) fifoRd <= 1'b1;
      @(posedge mclk) fifoRd <= 1'b0;
      repeat (2) @(posedge mclk);
    end
  endtask
  task automatic pkt(input int n, input logic [7:0] b0, input handshake_t exp);
    u_usb_host_model.outPkt(n, b0, hs);
    chk("out answer", 16'(hs), 16'(exp));
    repeat (2) @(posedge mclk);
  endtask
  task automatic inChk(input bit ack, input logic [7:0] exp);
    u_usb_host_model.inTrans(ack, hs, b);
    chk("in nakked", 16'(hs == HS_NAK || hs == HS_STALL), 16'h0000);
    chk("in byte", 16'(b), 16'(exp));
    repeat (3) @(posedge mclk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    {reset, dualBank, busActive, busReset, stallReq, fifoWr, fifoRd} = 7'h50;
    fw     = 7'h00;
    {defEp, wakeEn, wakeReq} = 3'h4;
    wrData = 8'h00;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      pkt(int'(rows[i].len), 8'h30, HS_ACK);
      chk("count", 16'(status.rxByteCount), 16'(rows[i].cnt));
      chk("full irq", 16'({status.rxBank0Full, epIrq}), 16'h0003);
      rdChk(int'(rows[i].cnt), 8'h30);
      fws(2);
    end
    $display("test rows done");
    pkt(4, 8'h50, HS_ACK);
    pkt(4, 8'h60, HS_NAK);
    rdChk(4, 8'h50);
    fws(2);
    pkt(2, 8'h70, HS_ACK);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    chk("reset", 32'({status, epIrq, suspended, devState, handshake}), 32'h0000_0000);
    $display("test single bank done");
    dualBank <= 1'b1;
    pkt(3, 8'h10, HS_ACK);
    pkt(5, 8'h20, HS_ACK);
    chk("both full", 16'({status.rxBank0Full, status.rxBank1Full}), 16'h0003);
    pkt(2, 8'h40, HS_NAK);
    chk("count 0", 16'(status.rxByteCount), 16'h0003);
    rdChk(3, 8'h10);
    fws(2);
    chk("count 1", 16'({status.rxByteCount, epIrq}), 16'h000b);
    rdChk(5, 8'h20);
    pkt(1, 8'h77, HS_ACK);
    fws(3);
    rdChk(1, 8'h77);
    fws(2);
    chk("rx idle", 16'({status.rxBank0Full, status.rxBank1Full, epIrq}), 16'h0000);
    $display("test dual bank done");
    u_usb_host_model.inTrans(1'b1, hs, b);
    chk("in idle", 16'(hs), 16'(HS_NAK));
    chk("tx ready", 16'(status.txPacketReady), 16'h0000);
    wr(8'ha1);
    fws(0);
    wr(8'hb1);
    inChk(1'b0, 8'ha1);
    chk("no ack", 16'(status.txComplete), 16'h0000);
    inChk(1'b1, 8'ha1);
    chk("tx done", 16'({status.txComplete, epIrq}), 16'h0003);
    chk("in bank", 32'(inBk), 32'h0000_0001);
    fws(0);
    fws(1);
    inChk(1'b1, 8'hb1);
    chk("tx done 1", 16'(status.txComplete), 16'h0001);
    fws(1);
    u_usb_host_model.inTrans(1'b1, hs, b);
    chk("in drained", 16'(hs), 16'(HS_NAK));
    $display("test in done");
    stallReq <= 1'b1;
    u_usb_host_model.inTrans(1'b0, hs, b);
    chk("stall", 16'(hs), 16'(HS_STALL));
    stallReq <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("stall sent", 16'({status.stallSentFlag, epIrq}), 16'h0003);
    fws(4);
    chk("stall clr", 16'({status.stallSentFlag, epIrq}), 16'h0000);
    pkt(2, 8'h33, HS_ACK);
    fws(6);
    chk("config early", 32'(devState), 32'(DEV_DEFAULT));
    fws(5);
    chk("addressed", 32'(devState), 32'(DEV_ADDRESS));
    fws(6);
    chk("configured", 32'(devState), 32'(DEV_CONFIGURED));
    busReset <= 1'b1;
    @(posedge mclk) busReset <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("bus reset", 32'({status, devState}), 32'h0000_0000);
    busActive <= 1'b0;
    repeat (30) @(posedge mclk);
    chk("suspend", 16'(suspended), 16'h0001);
    wakeReq <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("wake disabled", 32'(wakeRes), 32'h0000_0000);
    wakeEn <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("wake", 32'(wakeRes), 32'h0000_0001);
    {wakeEn, wakeReq} <= 2'b00;
    busActive <= 1'b1;
    repeat (6) @(posedge mclk);
    chk("resume", 32'({suspended, wakeRes}), 32'h0000_0000);
    $display("test stall and suspend done");
    results();
  end
endmodule
